// *** design/irq_pkg.sv ***
// Constants, register map and types of the two-level interrupt controller.
// Assumes one 25 MHz system clock and an 8-bit special function register
// port shared with the CPU core.
package irq_pkg;

  // ***************************************************************
  // Register addresses
  // ***************************************************************
  localparam logic [7:0] ADDR_PIN_CFG  = 8'he4;  // ext_int_pin_config
  localparam logic [7:0] ADDR_EXT_EN1  = 8'he6;  // extended_irq_enable_one
  localparam logic [7:0] ADDR_BASE_EN  = 8'hc0;  // base_irq_enable
  localparam logic [7:0] ADDR_EXT_EN2  = 8'hc1;  // extended_irq_enable_two
  localparam logic [7:0] ADDR_PRIO_A   = 8'hc2;  // priority_reg_a
  localparam logic [7:0] ADDR_PRIO_B   = 8'hc3;  // priority_reg_b

  // ***************************************************************
  // Reset values and write masks
  // ***************************************************************
  localparam logic [7:0] PIN_CFG_RST   = 8'h01;
  localparam logic [7:0] EXT_EN1_RST   = 8'h00;
  localparam logic [7:0] BASE_EN_RST   = 8'h00;
  localparam logic [7:0] EXT_EN2_RST   = 8'h00;
  localparam logic [7:0] PRIO_RST      = 8'h00;
  localparam logic [7:0] EXT_EN1_WMASK = 8'h3f;
  localparam logic [7:0] EXT_EN2_WMASK = 8'h03;
  localparam logic [7:0] PRIO_A_WMASK  = 8'h7f;
  localparam logic [7:0] READ_ZERO     = 8'h00;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int EN1_COMPARATOR = 5;
  localparam int EN1_CONV_DONE  = 4;
  localparam int EN1_COUNTER    = 3;
  localparam int EN1_WINDOW     = 2;
  localparam int EN1_MATCH      = 1;
  localparam int EN1_TWO_WIRE   = 0;
  localparam int PIN_ONE_POL    = 7;
  localparam int PIN_ONE_SEL_HI = 6;
  localparam int PIN_ONE_SEL_LO = 4;
  localparam int PIN_ZERO_POL   = 3;
  localparam int PIN_ZERO_SEL_HI = 2;
  localparam int PIN_ZERO_SEL_LO = 0;
  localparam int BASE_EN_GLOBAL = 7;
  localparam int BASE_EN_LAST   = 6;
  localparam int EXT_EN2_LAST   = 1;
  localparam int PRIO_A_LAST    = 6;

  // ***************************************************************
  // Sources in fixed arbitration order, index 0 first
  // ***************************************************************
  localparam int NUM_SRC        = 15;
  localparam int SRC_W          = 4;
  localparam int SRC_EXT_ZERO   = 0;
  localparam int SRC_EXT_ONE    = 2;
  localparam int SRC_TWO_WIRE   = 7;
  localparam int SRC_COMPARATOR = 12;
  localparam int SRC_LAST_EXT2  = 14;
  localparam int SRC_FIRST_EXT2 = 13;
  localparam int SRC_LAST_BASE  = 6;
  localparam int SRC_PRIO_B_LO  = 7;
  localparam int PIN_COUNT      = 8;
  localparam int PIN_SEL_W      = 3;

  // Vector table layout, plain defaults
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;

  // ***************************************************************
  // Clock period in ns, other timing in system clock cycles
  // ***************************************************************
  localparam int CLK_PERIOD_NS  = 40;
  localparam int DETECT_CYCLES  = 1;
  localparam int LONG_CALL_INSTR_CYCLES   = 4;
  localparam int RETURN_FROM_IRQ_INSTR_CYCLES    = 5;
  localparam int DIV_CYCLES     = 8;
  localparam int MIN_RESPONSE   = DETECT_CYCLES + LONG_CALL_INSTR_CYCLES;
  localparam int WORST_RESPONSE = DETECT_CYCLES + RETURN_FROM_IRQ_INSTR_CYCLES
                                  + DIV_CYCLES + LONG_CALL_INSTR_CYCLES;
  localparam int CNT_W          = 3;

  typedef enum logic [0:0] {ST_IDLE, ST_CALL} call_state_e;

endpackage : irq_pkg

// *** design/ext_pin_monitor.sv ***
// Watches one selected port 0 pin for an external interrupt input.
// Assumes the pins come from outside the clock domain and that the pin
// crossbar drives them; this module only reads them.
`timescale 1ns/1ps

module ext_pin_monitor
  import irq_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // Pin side
  input  wire logic [PIN_COUNT-1:0] port_pins,
  // Configuration
  input  wire logic [PIN_SEL_W-1:0] pin_select,
  input  wire logic                 polarity,
  // Result
  output logic                      active
);
  import irq_pkg::*;

  // ***************************************************************
  // Two-stage synchroniser, then select and polarity
  // ***************************************************************
  logic [PIN_COUNT-1:0] sync1_r;
  logic [PIN_COUNT-1:0] sync2_r;
  logic                 active_r;
  logic [PIN_COUNT-1:0] sync1_nxt;
  logic [PIN_COUNT-1:0] sync2_nxt;
  logic                 active_nxt;

  always_comb begin
    sync1_nxt  = port_pins;
    sync2_nxt  = sync1_r;
    // Read only, crossbar routing untouched
    active_nxt = sync2_r[pin_select] ~^ polarity;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_r  <= '0;
      sync2_r  <= '0;
      active_r <= 1'b0;
    end else begin
      sync1_r  <= sync1_nxt;
      sync2_r  <= sync2_nxt;
      active_r <= active_nxt;
    end
  end

  assign active = active_r;

endmodule : ext_pin_monitor

// *** design/two_level_interrupt_controller.sv ***
// Two-level interrupt controller: enables, priorities, arbitration and
// vector call sequencing toward the CPU core.
// Assumes peripherals hold their pending flags as levels on clk_sys and
// that the core reports instruction boundaries, returns and completions.
//
// Summary of operation
// - Fifteen sources exist, each with its own pending flag and vector.
// - A flag set by software raises a request just like a hardware one.
// - High level preempts a low handler; nothing preempts a high one.
// - Per-source priority bits sit in two registers, low after reset.
// - Higher level wins first, then a fixed source order breaks ties.
// - All requests are sampled and decoded in every clock cycle.
// - Fastest response is one detect cycle plus a four-cycle call.
// - After a return with a request pending, one instruction runs first.
// - Worst response without blocking is 1+5+8+4 = 18 cycles.
// - Equal or lower requests wait for the return and next instruction.
// - Enable bit 5 gates both comparator edge flags.
// - Enable bits 4..0 gate done, counter, window, match and two-wire.
// - Polarity bits 7 and 3 pick active low (0) or high (1) inputs.
// - Select fields 6:4 and 2:0 pick port 0 pin n for inputs one, zero.
// - Pin monitoring only observes the pin, crossbar untouched.
`timescale 1ns/1ps

module two_level_interrupt_controller
  import irq_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // Special function register port
  input  wire logic [7:0]           sfr_addr,
  input  wire logic                 sfr_wr,
  input  wire logic [7:0]           sfr_wdata,
  input  wire logic                 sfr_rd,
  output logic [7:0]                sfr_rdata,
  // Peripheral pending flags
  input  wire logic [NUM_SRC-1:0]   periph_flags,
  input  wire logic                 comparator_rise_flag,
  input  wire logic                 comparator_fall_flag,
  // Port 0 pins
  input  wire logic [PIN_COUNT-1:0] port0_pins,
  // CPU core status
  input  wire logic                 cpu_boundary,
  input  wire logic                 cpu_instr_done,
  input  wire logic                 cpu_return_from_irq_instr,
  // Vector call toward the core
  output logic                      call_start,
  output logic                      call_busy,
  output logic [15:0]               vector_addr,
  output logic [SRC_W-1:0]          vector_src,
  output logic                      call_high,
  output logic                      high_active,
  output logic                      low_active
);
  import irq_pkg::*;

  // ***************************************************************
  // Register file
  // ***************************************************************
  logic [7:0] pin_cfg_r;
  logic [7:0] ext_en1_r;
  logic [7:0] base_en_r;
  logic [7:0] ext_en2_r;
  logic [7:0] prio_a_r;
  logic [7:0] prio_b_r;
  logic [7:0] rdata_r;
  logic [7:0] pin_cfg_nxt;
  logic [7:0] ext_en1_nxt;
  logic [7:0] base_en_nxt;
  logic [7:0] ext_en2_nxt;
  logic [7:0] prio_a_nxt;
  logic [7:0] prio_b_nxt;
  logic [7:0] rdata_nxt;

  always_comb begin
    pin_cfg_nxt = pin_cfg_r;
    ext_en1_nxt = ext_en1_r;
    base_en_nxt = base_en_r;
    ext_en2_nxt = ext_en2_r;
    prio_a_nxt  = prio_a_r;
    prio_b_nxt  = prio_b_r;
    if (sfr_wr) begin
      case (sfr_addr)
        ADDR_PIN_CFG: pin_cfg_nxt = sfr_wdata;
        // Reserved bits 7:6 are not stored
        ADDR_EXT_EN1: ext_en1_nxt = sfr_wdata & EXT_EN1_WMASK;
        ADDR_BASE_EN: base_en_nxt = sfr_wdata;
        ADDR_EXT_EN2: ext_en2_nxt = sfr_wdata & EXT_EN2_WMASK;
        ADDR_PRIO_A:  prio_a_nxt  = sfr_wdata & PRIO_A_WMASK;
        ADDR_PRIO_B:  prio_b_nxt  = sfr_wdata;
        default: ;
      endcase
    end
    rdata_nxt = READ_ZERO;
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_PIN_CFG: rdata_nxt = pin_cfg_r;
        ADDR_EXT_EN1: rdata_nxt = ext_en1_r;
        ADDR_BASE_EN: rdata_nxt = base_en_r;
        ADDR_EXT_EN2: rdata_nxt = ext_en2_r;
        ADDR_PRIO_A:  rdata_nxt = prio_a_r;
        ADDR_PRIO_B:  rdata_nxt = prio_b_r;
        default:      rdata_nxt = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_cfg_r <= PIN_CFG_RST;
      ext_en1_r <= EXT_EN1_RST;
      base_en_r <= BASE_EN_RST;
      ext_en2_r <= EXT_EN2_RST;
      prio_a_r  <= PRIO_RST;
      prio_b_r  <= PRIO_RST;
      rdata_r   <= READ_ZERO;
    end else begin
      pin_cfg_r <= pin_cfg_nxt;
      ext_en1_r <= ext_en1_nxt;
      base_en_r <= base_en_nxt;
      ext_en2_r <= ext_en2_nxt;
      prio_a_r  <= prio_a_nxt;
      prio_b_r  <= prio_b_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ***************************************************************
  // External inputs from port 0
  // ***************************************************************
  logic ext_zero_active;
  logic ext_one_active;

  ext_pin_monitor u_ext_zero (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .port_pins  (port0_pins),
    .pin_select (pin_cfg_r[PIN_ZERO_SEL_HI:PIN_ZERO_SEL_LO]),
    .polarity   (pin_cfg_r[PIN_ZERO_POL]),
    .active     (ext_zero_active)
  );

  ext_pin_monitor u_ext_one (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .port_pins  (port0_pins),
    .pin_select (pin_cfg_r[PIN_ONE_SEL_HI:PIN_ONE_SEL_LO]),
    .polarity   (pin_cfg_r[PIN_ONE_POL]),
    .active     (ext_one_active)
  );

  // ***************************************************************
  // Per-source flag, enable and priority
  // ***************************************************************
  logic [NUM_SRC-1:0] src_flag;
  logic [NUM_SRC-1:0] src_en;
  logic [NUM_SRC-1:0] src_prio;
  logic [NUM_SRC-1:0] req_any;
  logic [NUM_SRC-1:0] req_high;
  logic               global_en;

  assign global_en = base_en_r[BASE_EN_GLOBAL];
  // Two-wire, match, window, counter, done, comparator
  assign src_en[SRC_COMPARATOR:SRC_TWO_WIRE] = ext_en1_r[EN1_COMPARATOR:
                                                         EN1_TWO_WIRE];
  assign src_en[SRC_LAST_BASE:0] = base_en_r[BASE_EN_LAST:0];
  assign src_en[SRC_LAST_EXT2:SRC_FIRST_EXT2] = ext_en2_r[EXT_EN2_LAST:0];
  assign src_prio[SRC_LAST_BASE:0] = prio_a_r[PRIO_A_LAST:0];
  assign src_prio[SRC_LAST_EXT2:SRC_PRIO_B_LO] = prio_b_r;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      if (gi == SRC_EXT_ZERO) begin : g_ext0
        assign src_flag[gi] = ext_zero_active;
      end else if (gi == SRC_EXT_ONE) begin : g_ext1
        assign src_flag[gi] = ext_one_active;
      end else if (gi == SRC_COMPARATOR) begin : g_cmp
        // Both edge flags share one source
        assign src_flag[gi] = comparator_rise_flag | comparator_fall_flag;
      end else begin : g_per
        // Software-set flags look the same as hardware ones
        assign src_flag[gi] = periph_flags[gi];
      end
      // Flags only read, never cleared here
      assign req_any[gi]  = src_flag[gi] & src_en[gi] & global_en;
      assign req_high[gi] = req_any[gi] & src_prio[gi];
    end
  endgenerate

  // ***************************************************************
  // Arbitration, decoded every cycle
  // ***************************************************************
  logic             high_any;
  logic             low_any;
  logic [SRC_W-1:0] high_idx;
  logic [SRC_W-1:0] low_idx;

  always_comb begin
    high_any = 1'b0;
    low_any  = 1'b0;
    high_idx = '0;
    low_idx  = '0;
    // Lowest index wins within a level
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req_high[i]) begin
        high_any = 1'b1;
        high_idx = SRC_W'(i);
      end
      if (req_any[i] && !src_prio[i]) begin
        low_any = 1'b1;
        low_idx = SRC_W'(i);
      end
    end
  end

  // ***************************************************************
  // Handler tracking and vector call sequencing
  // ***************************************************************
  call_state_e      state_r;
  logic [CNT_W-1:0] cnt_r;
  logic             start_r;
  logic [15:0]      vec_r;
  logic [SRC_W-1:0] src_r;
  logic             lvl_r;
  logic             hi_act_r;
  logic             lo_act_r;
  logic             hold_r;
  call_state_e      state_nxt;
  logic [CNT_W-1:0] cnt_nxt;
  logic             start_nxt;
  logic [15:0]      vec_nxt;
  logic [SRC_W-1:0] src_nxt;
  logic             lvl_nxt;
  logic             hi_act_nxt;
  logic             lo_act_nxt;
  logic             hold_nxt;
  logic             take_high;
  logic             take_low;

  always_comb begin
    // High may enter unless a high handler runs
    take_high = high_any && !hi_act_r;
    // Low waits for any running handler
    take_low  = !high_any && low_any && !hi_act_r && !lo_act_r;
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    start_nxt  = 1'b0;
    vec_nxt    = vec_r;
    src_nxt    = src_r;
    lvl_nxt    = lvl_r;
    hi_act_nxt = hi_act_r;
    lo_act_nxt = lo_act_r;
    hold_nxt   = hold_r;
    // One more instruction after a return
    if (cpu_return_from_irq_instr) begin
      hold_nxt = 1'b1;
      if (hi_act_r) begin
        hi_act_nxt = 1'b0;
      end else begin
        lo_act_nxt = 1'b0;
      end
    end else if (cpu_instr_done) begin
      hold_nxt = 1'b0;
    end
    case (state_r)
      ST_IDLE: begin
        // Detect cycle is this sampling edge
        if (cpu_boundary && !hold_r && !cpu_return_from_irq_instr &&
            (take_high || take_low)) begin
          state_nxt = ST_CALL;
          cnt_nxt   = CNT_W'(LONG_CALL_INSTR_CYCLES - 1);
          start_nxt = 1'b1;
          src_nxt   = take_high ? high_idx : low_idx;
          vec_nxt   = 16'(VEC_BASE + VEC_STEP * src_nxt);
          lvl_nxt   = take_high;
          if (take_high) begin
            hi_act_nxt = 1'b1;
          end else begin
            lo_act_nxt = 1'b1;
          end
        end
      end
      ST_CALL: begin
        if (cnt_r == '0) begin
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r  <= ST_IDLE;
      cnt_r    <= '0;
      start_r  <= 1'b0;
      vec_r    <= '0;
      src_r    <= '0;
      lvl_r    <= 1'b0;
      hi_act_r <= 1'b0;
      lo_act_r <= 1'b0;
      hold_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      start_r  <= start_nxt;
      vec_r    <= vec_nxt;
      src_r    <= src_nxt;
      lvl_r    <= lvl_nxt;
      hi_act_r <= hi_act_nxt;
      lo_act_r <= lo_act_nxt;
      hold_r   <= hold_nxt;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign sfr_rdata   = rdata_r;
  assign call_start  = start_r;
  assign call_busy   = (state_r == ST_CALL);
  assign vector_addr = vec_r;
  assign vector_src  = src_r;
  assign call_high   = lvl_r;
  assign high_active = hi_act_r;
  assign low_active  = lo_act_r;

endmodule : two_level_interrupt_controller

// *** tb/irq_asserts.sv ***
// Checker of the interrupt controller's call sequencing and registers.
// Assumes it is bound to the controller top and sees only its ports.
`timescale 1ns/1ps

module irq_asserts (
  // Clock and reset
  input logic                      clk_sys,
  input logic                      rst,
  // Register port
  input logic [7:0]                sfr_addr,
  input logic                      sfr_rd,
  input logic [7:0]                sfr_rdata,
  // Core status
  input logic                      cpu_instr_done,
  input logic                      cpu_return_from_irq_instr,
  // Vector call
  input logic                      call_start,
  input logic                      call_busy,
  input logic [15:0]               vector_addr,
  input logic [irq_pkg::SRC_W-1:0] vector_src,
  input logic                      call_high,
  input logic                      high_active,
  input logic                      low_active
);
  import irq_pkg::*;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Set by a return, cleared by the next ordinary instruction
  logic hold_r;
  logic hold_nxt;

  always_comb begin
    hold_nxt = hold_r;
    if (cpu_return_from_irq_instr)
      hold_nxt = 1'b1;
    else if (cpu_instr_done)
      hold_nxt = 1'b0;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      hold_r <= 1'b0;
    else
      hold_r <= hold_nxt;
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_CALL_LEN: assert property (call_start |-> $rose(call_busy)
    ##1 call_busy [*3] ##1 !call_busy) else $error("call length wrong");
  AST_START_EDGE: assert property ($rose(call_busy) |-> call_start)
    else $error("busy without start");
  AST_VEC_ADDR: assert property (call_start |->
    vector_addr == VEC_BASE + VEC_STEP * vector_src) else $error("bad vector");
  AST_VEC_HELD: assert property (!call_start |->
    $stable(vector_src) && $stable(vector_addr)) else $error("vector moved");
  AST_HIGH_FINAL: assert property ($past(high_active)
    |-> !call_start) else $error("high handler preempted");
  AST_LOW_PREEMPT: assert property (call_start && $past(low_active)
    |-> call_high) else $error("low handler preempted by low");
  AST_ACTIVE_SET: assert property (call_start |->
    (call_high ? high_active : low_active)) else $error("level not marked");
  AST_RETURN_FROM_IRQ_INSTR_HIGH: assert property (cpu_return_from_irq_instr && high_active
    |=> !high_active) else $error("high level not released");
  AST_RETURN_FROM_IRQ_INSTR_LOW: assert property (cpu_return_from_irq_instr && !high_active
    |=> !low_active) else $error("low level not released");
  AST_HOLD: assert property ((hold_r || cpu_return_from_irq_instr) |=> !call_start)
    else $error("call before instruction after return");
  AST_EN1_RSV: assert property (sfr_rd && sfr_addr == ADDR_EXT_EN1
    |=> sfr_rdata[7:6] == 2'b00) else $error("reserved enable bits set");

  cover property (call_start && call_high);
  cover property (call_start && $past(low_active));
  cover property (cpu_return_from_irq_instr ##1 hold_r);

endmodule : irq_asserts

bind two_level_interrupt_controller irq_asserts irq_asserts_i (
  .clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .cpu_instr_done(cpu_instr_done),
  .cpu_return_from_irq_instr(cpu_return_from_irq_instr), .call_start(call_start), .call_busy(call_busy),
  .vector_addr(vector_addr), .vector_src(vector_src),
  .call_high(call_high), .high_active(high_active),
  .low_active(low_active));

// *** tb/cpu_core_model.sv ***
// Behavioural model of the CPU core's instruction boundaries and returns.
// Assumes the bench sets the instruction length and asks for returns.
`timescale 1ns/1ps

module cpu_core_model (
  // Clock and reset
  input  logic       clk_sys,
  input  logic       rst,
  // Bench controls
  input  logic [3:0] instr_len,
  input  logic       ret_req,
  // Controller side
  input  logic       call_busy,
  output logic       cpu_boundary,
  output logic       cpu_instr_done,
  output logic       cpu_return_from_irq_instr
);
  logic [3:0] cnt_r;
  logic       ret_r;

  // No boundary while a vector call runs
  assign cpu_boundary   = !call_busy && cnt_r == 4'h0;
  assign cpu_instr_done = cpu_boundary;
  assign cpu_return_from_irq_instr       = cpu_boundary && ret_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      ret_r <= 1'b0;
    end else begin
      if (ret_req)
        ret_r <= 1'b1;
      else if (cpu_return_from_irq_instr)
        ret_r <= 1'b0;
      // Length 7 gives the eight-cycle divide
      if (cpu_boundary)
        cnt_r <= instr_len;
      else if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
    end
  end

endmodule : cpu_core_model

// *** tb/tb.sv ***
// Self-checking bench of the two-level interrupt controller.
// Assumes the core model drives the status lines, the bench the rest.
`timescale 1ns/1ps

module tb;
  import irq_pkg::*;

  logic                 clk_sys, rst, sfr_wr, sfr_rd, ret_req;
  logic [7:0]           sfr_addr, sfr_wdata, sfr_rdata;
  logic [NUM_SRC-1:0]   periph_flags;
  logic                 comparator_rise_flag, comparator_fall_flag;
  logic [PIN_COUNT-1:0] port0_pins;
  logic                 cpu_boundary, cpu_instr_done, cpu_return_from_irq_instr;
  logic                 call_start, call_busy, call_high;
  logic                 high_active, low_active;
  logic [15:0]          vector_addr;
  logic [SRC_W-1:0]     vector_src;
  logic [3:0]           instr_len;
  int                   n_fail, compares;

  two_level_interrupt_controller two_level_interrupt_controller_i (
    .clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .periph_flags(periph_flags), .comparator_rise_flag(comparator_rise_flag),
    .comparator_fall_flag(comparator_fall_flag), .port0_pins(port0_pins),
    .cpu_boundary(cpu_boundary), .cpu_instr_done(cpu_instr_done),
    .cpu_return_from_irq_instr(cpu_return_from_irq_instr), .call_start(call_start), .call_busy(call_busy),
    .vector_addr(vector_addr), .vector_src(vector_src),
    .call_high(call_high), .high_active(high_active),
    .low_active(low_active));

  cpu_core_model cpu_core_model_i (
    .clk_sys(clk_sys), .rst(rst), .instr_len(instr_len), .ret_req(ret_req),
    .call_busy(call_busy), .cpu_boundary(cpu_boundary),
    .cpu_instr_done(cpu_instr_done), .cpu_return_from_irq_instr(cpu_return_from_irq_instr));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk_sys) sfr_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clk_sys) sfr_rd <= 1'b0;
    #1;
    chk("sfr_rdata", sfr_rdata, exp);
  endtask : rd

  task automatic vec_call(input int src, input logic hi, output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (call_start !== 1'b1 && n < 20);
    chk("call_start", call_start, 1'b1);
    chk("vector_src", vector_src, 16'(src));
    chk("call_high", call_high, hi);
    chk("vector_addr", vector_addr, VEC_BASE + VEC_STEP * 16'(src));
  endtask : vec_call

  task automatic no_call(input int k);
    repeat (k) begin
      @(posedge clk_sys);
      #1;
      chk("no call", call_start, 1'b0);
    end
  endtask : no_call

  task automatic ret;
    int k;
    k = 0;
    @(posedge clk_sys) ret_req <= 1'b1;
    @(posedge clk_sys) ret_req <= 1'b0;
    #1;
    while (cpu_return_from_irq_instr !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
  endtask : ret

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rd(ADDR_PIN_CFG, 8'h01);
    rd(ADDR_EXT_EN1, 8'h00);
    rd(ADDR_PRIO_A, 8'h00);
    rd(ADDR_PRIO_B, 8'h00);
    wr(ADDR_EXT_EN1, 8'hff);
    rd(ADDR_EXT_EN1, 8'h3f);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
  endtask : t_regs

  task automatic t_lat;
    int n;
    wr(ADDR_BASE_EN, 8'h80);
    wr(ADDR_EXT_EN1, 8'h01);
    @(posedge clk_sys) periph_flags[7] <= 1'b1;
    vec_call(7, 1'b0, n);
    chk("latency", 16'(n), 16'(DETECT_CYCLES));
    chk("call_busy", call_busy, 1'b1);
    @(posedge clk_sys) periph_flags[7] <= 1'b0;
    ret();
    @(posedge clk_sys) instr_len <= 4'h7;
    @(posedge clk_sys) periph_flags[7] <= 1'b1;
    vec_call(7, 1'b0, n);
    chk("slow", 16'(n <= WORST_RESPONSE - LONG_CALL_INSTR_CYCLES), 16'h1);
    @(posedge clk_sys) periph_flags[7] <= 1'b0;
    ret();
    @(posedge clk_sys) instr_len <= 4'h0;
  endtask : t_lat

  task automatic t_mask;
    int n;
    for (int b = 0; b < 7; b++) begin
      wr(ADDR_EXT_EN1, 8'h00);
      @(posedge clk_sys);
      comparator_rise_flag <= (b == 5);
      comparator_fall_flag <= (b == 6);
      if (b < 5)
        periph_flags[7 + b] <= 1'b1;
      no_call(4);
      wr(ADDR_EXT_EN1, 8'h01 << (b < 6 ? b : 5));
      vec_call(b < 5 ? 7 + b : SRC_COMPARATOR, 1'b0, n);
      @(posedge clk_sys);
      periph_flags <= 15'h0000;
      comparator_rise_flag <= 1'b0;
      comparator_fall_flag <= 1'b0;
      ret();
    end
  endtask : t_mask

  task automatic t_prio;
    int n;
    wr(ADDR_EXT_EN1, 8'h06);
    wr(ADDR_PRIO_B, 8'h04);
    @(posedge clk_sys) periph_flags[9:8] <= 2'b11;
    vec_call(9, 1'b1, n);
    chk("high_active", high_active, 1'b1);
    no_call(6);
    @(posedge clk_sys) periph_flags[9] <= 1'b0;
    ret();
    vec_call(8, 1'b0, n);
    @(posedge clk_sys) periph_flags[9] <= 1'b1;
    vec_call(9, 1'b1, n);
    chk("low_active", low_active, 1'b1);
    @(posedge clk_sys) periph_flags[9] <= 1'b0;
    ret();
    no_call(4);
    @(posedge clk_sys) periph_flags[8] <= 1'b0;
    ret();
    wr(ADDR_PRIO_B, 8'h00);
    @(posedge clk_sys) periph_flags[9:8] <= 2'b11;
    vec_call(8, 1'b0, n);
    @(posedge clk_sys) periph_flags[8] <= 1'b0;
    ret();
    vec_call(9, 1'b0, n);
    @(posedge clk_sys) periph_flags[9] <= 1'b0;
    ret();
  endtask : t_prio

  task automatic t_pins;
    int n;
    wr(ADDR_PIN_CFG, 8'h08);
    wr(ADDR_BASE_EN, 8'h81);
    for (int p = 0; p < 8; p++) begin
      wr(ADDR_PIN_CFG, 8'h08 | 8'(p));
      @(posedge clk_sys) port0_pins <= ~(8'h01 << p);
      no_call(5);
      @(posedge clk_sys) port0_pins <= 8'hff;
      vec_call(SRC_EXT_ZERO, 1'b0, n);
      @(posedge clk_sys) port0_pins <= 8'h00;
      ret();
    end
    wr(ADDR_BASE_EN, 8'h80);
    @(posedge clk_sys) port0_pins <= 8'hff;
    wr(ADDR_PIN_CFG, 8'h50);
    wr(ADDR_PRIO_A, 8'h04);
    wr(ADDR_BASE_EN, 8'h85);
    no_call(5);
    @(posedge clk_sys) port0_pins <= 8'hdf;
    vec_call(SRC_EXT_ONE, 1'b1, n);
    @(posedge clk_sys) port0_pins <= 8'hff;
    ret();
  endtask : t_pins

  initial begin
    rst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    ret_req = 1'b0;
    instr_len = 4'h0;
    periph_flags = 15'h0000;
    comparator_rise_flag = 1'b0;
    comparator_fall_flag = 1'b0;
    port0_pins = 8'h00;
    n_fail = 0;
    compares = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_lat();
    t_mask();
    t_prio();
    t_pins();
    end_of_test();
  end

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    end_of_test();
  end

endmodule : tb
